//--- logic/dta_adjust.sv
// Dynamic fan-on threshold adjuster for the two remote temperature channels.
// Assumes a one-cycle monitor_tick per finished monitoring cycle and
// registers reached through a simple synchronous write and read port.
//
// Summary of operation
// (RULE1) The cycle selector register holds the channel 1 code in bits 2..0 and the channel 2 code in bits 5..3.
// (RULE2) Code 0 gives a short cycle of 8 monitoring cycles, doubling per step to 1024, and the long cycle is twice the short one.
// (RULE3) While temperature stays at or below target minus hysteresis and not below the low limit, the threshold is left alone.
// (RULE4) Each short cycle with temperature above target minus hysteresis lowers the threshold by twice the rise since the last short cycle.
// (RULE5) A rise of no more than a quarter degree per short cycle causes no short-cycle reduction.
// (RULE6) While temperature is above the target, each long cycle lowers the threshold by one degree on top of any short-cycle cut.
// (RULE7) Between target minus hysteresis and the target, the long cycle makes no change.
// (RULE8) A long cycle raises the threshold only if temperature is below the low limit and above the threshold, and the threshold is below both the high limit and the target.
// (RULE9) The threshold is never raised above the channel high limit.
// (RULE10) The threshold is clamped at minus 64 degrees.
// (RULE11) While temperature is below the threshold, adjustment of that channel is suspended.
// (RULE12) A permitted increase raises the threshold by one degree per long cycle.
// (RULE13) Adjustment runs only while the channel enable bit is set, bit 0 for channel 1 and bit 1 for channel 2.
// (RULE14) The hysteresis field in bits 7..4 says how far below the target reduction begins.
// (RULE15) Each channel has its own 8-bit target temperature register with one degree steps.
`timescale 1ns/1ps

module dta_adjust #(
    parameter int CHANNELS = 2
) (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Monitoring cadence
    input wire logic monitor_tick,
    // Register port
    input wire logic [7:0] reg_address,
    input wire logic reg_write,
    input wire logic [7:0] reg_write_data,
    input wire logic reg_read,
    output logic [7:0] reg_read_data,
    output logic reg_read_valid,
    // Measurements, limits and threshold loading
    input wire dta_pkg::dta_chan_in_type chan_in [CHANNELS],
    input wire dta_pkg::dta_load_type threshold_load [CHANNELS],
    // Adjusted thresholds
    output logic [7:0] fan_on_threshold [CHANNELS]
);

    // ==========================================================
    // Elaboration check
    if (CHANNELS != 2) begin : g_bad_channels
        $error("dta_adjust serves exactly two remote channels");
    end

    // ==========================================================
    // Register bank
    logic [1:0] adjust_enable;
    logic [5:0] adjust_cycle_select;
    logic [7:0] target_temperature [2];
    logic [3:0] hysteresis;
    logic [7:0] read_data;
    logic [1:0] next_adjust_enable;
    logic [5:0] next_adjust_cycle_select;
    logic [7:0] next_target_temperature [2];
    logic [3:0] next_hysteresis;
    logic [7:0] next_read_data;
    logic next_read_valid;

    always_comb begin
        next_adjust_enable = adjust_enable;
        next_adjust_cycle_select = adjust_cycle_select;
        next_target_temperature = target_temperature;
        next_hysteresis = hysteresis;
        if (reg_write) begin
            case (reg_address)
                dta_pkg::ADJUST_ENABLE_OFFSET: begin
                    next_adjust_enable = reg_write_data[1:0]; // [RULE13]
                end
                dta_pkg::ADJUST_CYCLE_SELECT_OFFSET: begin
                    next_adjust_cycle_select = reg_write_data[5:0]; // [RULE1]
                end
                dta_pkg::TARGET1_OFFSET: begin
                    next_target_temperature[0] = reg_write_data; // [RULE15]
                end
                dta_pkg::TARGET2_OFFSET: begin
                    next_target_temperature[1] = reg_write_data; // [RULE15]
                end
                dta_pkg::HYSTERESIS_OFFSET: begin
                    next_hysteresis = reg_write_data[7:4]; // [RULE14]
                end
                default: begin
                end
            endcase
        end
        // Unmapped and reserved bits read as zero.
        next_read_data = 8'h00;
        next_read_valid = reg_read;
        if (reg_read) begin
            case (reg_address)
                dta_pkg::ADJUST_ENABLE_OFFSET: begin
                    next_read_data = {6'h00, adjust_enable};
                end
                dta_pkg::ADJUST_CYCLE_SELECT_OFFSET: begin
                    next_read_data = {2'h0, adjust_cycle_select};
                end
                dta_pkg::TARGET1_OFFSET: begin
                    next_read_data = target_temperature[0];
                end
                dta_pkg::TARGET2_OFFSET: begin
                    next_read_data = target_temperature[1];
                end
                dta_pkg::HYSTERESIS_OFFSET: begin
                    next_read_data = {hysteresis, 4'h0};
                end
                default: begin
                    next_read_data = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            adjust_enable <= dta_pkg::ENABLE_RESET;
            adjust_cycle_select <= dta_pkg::CYCLE_SELECT_RESET;
            target_temperature[0] <= dta_pkg::TARGET_RESET;
            target_temperature[1] <= dta_pkg::TARGET_RESET;
            hysteresis <= dta_pkg::HYSTERESIS_RESET;
            read_data <= 8'h00;
            reg_read_valid <= 1'b0;
        end else begin
            adjust_enable <= next_adjust_enable;
            adjust_cycle_select <= next_adjust_cycle_select;
            target_temperature <= next_target_temperature;
            hysteresis <= next_hysteresis;
            read_data <= next_read_data;
            reg_read_valid <= next_read_valid;
        end
    end

    assign reg_read_data = read_data;

    // ==========================================================
    // Per-channel adjustment loop
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        localparam int CODE_LSB = (ch == 0) ? dta_pkg::CHAN1_CYCLE_CODE_LSB
                                            : dta_pkg::CHAN2_CYCLE_CODE_LSB;
        logic [2:0] cycle_code;
        logic [10:0] tick_count;
        logic [10:0] short_mask;
        logic [10:0] long_mask;
        logic short_event;
        logic long_event;
        logic [9:0] last_sample;
        logic [7:0] threshold;
        logic signed [11:0] temp_q;
        logic signed [11:0] target_q;
        logic signed [11:0] band_q;
        logic signed [11:0] thr_q;
        logic signed [11:0] rise_q;
        logic signed [11:0] work;
        logic [8:0] short_cut;
        logic long_cut;
        logic raise;
        logic active;
        logic [10:0] next_tick_count;
        logic [9:0] next_last_sample;
        logic [7:0] next_threshold;

        assign cycle_code = adjust_cycle_select[CODE_LSB +: 3];
        // Short period is 8 << code ticks; the long period is double.
        assign short_mask = 11'((dta_pkg::SHORT_CYCLE_BASE << cycle_code)
                                - 1); // [RULE2]
        assign long_mask = {short_mask[9:0], 1'b1}; // [RULE2]
        assign short_event = monitor_tick &&
                             ((tick_count & short_mask) == short_mask);
        assign long_event = monitor_tick &&
                            ((tick_count & long_mask) == long_mask);

        // Comparisons run in quarter degrees, except the raise limit checks, which use whole degrees.
        assign temp_q = $signed({2'b00, chan_in[ch].temperature});
        assign target_q = $signed({2'b00, target_temperature[ch], 2'b00});
        assign band_q = target_q -
                        $signed({6'h00, hysteresis, 2'b00}); // [RULE14]
        assign thr_q = $signed({2'b00, threshold, 2'b00});
        assign rise_q = temp_q - $signed({2'b00, last_sample});

        // Suspended below the threshold, and whenever disabled.
        assign active = adjust_enable[ch] && (temp_q >= thr_q); // [RULE11] [RULE13]

        always_comb begin
            short_cut = 9'h000;
            long_cut = 1'b0;
            raise = 1'b0;
            // Quarter-degree rise halved gives twice the rise in degrees.
            if (short_event && active && temp_q > band_q &&
                rise_q > $signed({1'b0, dta_pkg::SLOW_RISE_QUARTERS})) begin
                short_cut = 9'(rise_q >>> 1); // [RULE4] [RULE5] [RULE3]
            end
            if (long_event && active && temp_q > target_q) begin
                long_cut = 1'b1; // [RULE6] [RULE7]
            end
            if (long_event && active &&
                chan_in[ch].temperature[9:2] < chan_in[ch].low_limit &&
                temp_q > thr_q &&
                threshold < chan_in[ch].high_limit &&
                threshold < target_temperature[ch]) begin
                raise = 1'b1; // [RULE8] [RULE9]
            end
            work = $signed({4'h0, threshold}) - $signed({3'h0, short_cut}) -
                   $signed({11'h000, long_cut}) +
                   $signed({11'h000, raise}); // [RULE12]
            next_threshold = threshold;
            if (threshold_load[ch].load) begin
                next_threshold = threshold_load[ch].value;
            end else if (work < 0) begin
                next_threshold = dta_pkg::THRESHOLD_FLOOR; // [RULE10]
            end else begin
                next_threshold = work[7:0];
            end
            next_tick_count = monitor_tick ? tick_count + 11'h001
                                           : tick_count;
            next_last_sample = short_event ? chan_in[ch].temperature
                                           : last_sample;
        end

        // The threshold itself is loaded by software, so reset only clears it.
        always_ff @(posedge clock or negedge resetn) begin
            if (!resetn) begin
                tick_count <= 11'h000;
                last_sample <= 10'h000;
                threshold <= 8'h00;
            end else begin
                tick_count <= next_tick_count;
                last_sample <= next_last_sample;
                threshold <= next_threshold;
            end
        end

        assign fan_on_threshold[ch] = threshold;
    end

endmodule

//--- logic/dta_pkg.sv
// Constants and carrier types for the dynamic fan-on threshold adjuster.
// Assumes temperatures in offset-binary degrees, 0x40 standing for 0 degC.
package dta_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] ADJUST_ENABLE_OFFSET = 8'h0b;
    localparam logic [7:0] ADJUST_CYCLE_SELECT_OFFSET = 8'h0c;
    localparam logic [7:0] TARGET1_OFFSET = 8'h5a;
    localparam logic [7:0] TARGET2_OFFSET = 8'h5b;
    localparam logic [7:0] HYSTERESIS_OFFSET = 8'h64;

    // ==========================================================
    // Field positions
    localparam int CHAN1_CYCLE_CODE_LSB = 0;
    localparam int CHAN2_CYCLE_CODE_LSB = 3;
    localparam int CYCLE_CODE_WIDTH = 3;
    localparam int HYSTERESIS_LSB = 4;
    localparam int HYSTERESIS_WIDTH = 4;

    // ==========================================================
    // Reset values
    localparam logic [7:0] TARGET_RESET = 8'ha4;
    localparam logic [3:0] HYSTERESIS_RESET = 4'h4;
    localparam logic [1:0] ENABLE_RESET = 2'h0;
    localparam logic [5:0] CYCLE_SELECT_RESET = 6'h00;

    // ==========================================================
    // Timing, in monitoring cycles, and value limits
    localparam int SHORT_CYCLE_BASE = 8;
    localparam int CYCLE_COUNT_WIDTH = 11;
    localparam logic [7:0] THRESHOLD_FLOOR = 8'h00;
    localparam int FRACTION_BITS = 2;
    localparam logic [10:0] SLOW_RISE_QUARTERS = 11'h001;

    // ==========================================================
    // Per-channel measurement and limits.
    typedef struct packed {
        logic [9:0] temperature;
        logic [7:0] low_limit;
        logic [7:0] high_limit;
    } dta_chan_in_type;

    typedef struct packed {
        logic load;
        logic [7:0] value;
    } dta_load_type;

endpackage

//--- sim/dta_adjust_chk.sv
// Port assertions for the threshold adjuster, channel one side.
// Assumes a bind to dta_adjust from the bench top file.
`timescale 1ns/1ps

module dta_adjust_chk #(
    parameter int CHANNELS = 2
) (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Observed ports
    input wire logic monitor_tick,
    input wire logic reg_read,
    input wire logic reg_read_valid,
    input wire dta_pkg::dta_chan_in_type chan_in [CHANNELS],
    input wire dta_pkg::dta_load_type threshold_load [CHANNELS],
    input wire logic [7:0] fan_on_threshold [CHANNELS]
);
    // ==========
    // Views
    wire logic [7:0] thr = fan_on_threshold[0];
    wire logic ld = threshold_load[0].load;
    wire logic tk = monitor_tick && !ld;
    wire logic [9:0] tq = chan_in[0].temperature;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    // ==========
    // Properties
    property p_rd; reg_read |=> reg_read_valid; endproperty
    a_rd: assert property (p_rd) else $error("read lost");
    property p_nrd; !reg_read |=> !reg_read_valid; endproperty
    a_nrd: assert property (p_nrd) else $error("stray valid");
    // Two quiet cycles, so either answer latency is tolerated.
    property p_hold; (!monitor_tick && !ld)[*2] |=> $stable(thr); endproperty
    a_hold: assert property (p_hold) else $error("idle move");
    property p_ld; ld |=> thr == $past(threshold_load[0].value); endproperty
    a_ld: assert property (p_ld) else $error("load lost");
    property p_sus; tk && tq < {thr, 2'h0} |=> $stable(thr); endproperty
    a_sus: assert property (p_sus) else $error("not held");
    property p_up1;
        $past(tk) && thr > $past(thr) |-> thr == $past(thr) + 8'h01;
    endproperty
    a_up1: assert property (p_up1) else $error("raise size");
    property p_uphi;
        $past(tk) && thr > $past(thr) |-> thr <= chan_in[0].high_limit;
    endproperty
    a_uphi: assert property (p_uphi) else $error("above high");
    property p_uplo;
        $past(tk) && thr > $past(thr) |->
            $past(tq[9:2]) < $past(chan_in[0].low_limit);
    endproperty
    a_uplo: assert property (p_uplo) else $error("raise cause");
endmodule

//--- sim/test_dta_adjust.sv
// Self-checking bench for the dynamic fan-on threshold adjuster.
// Assumes dta_pkg, dta_adjust and the checker are compiled first.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] %s expected %h seen %h", n, e, g); end end

module test_dta_adjust;
    // ==========
    // Connections
    logic clock = 0;
    logic resetn = 0;
    logic monitor_tick = 0;
    logic [7:0] reg_address = 8'h00;
    logic reg_write = 0;
    logic [7:0] reg_write_data = 8'h00;
    logic reg_read = 0;
    logic [7:0] reg_read_data;
    logic reg_read_valid;
    dta_pkg::dta_chan_in_type chan_in [2];
    dta_pkg::dta_load_type threshold_load [2];
    logic [7:0] fan_on_threshold [2];
    logic [7:0] ra [6] = '{8'h0b, 8'h0c, 8'h5a, 8'h5b, 8'h64, 8'h33};
    logic [7:0] re [6] = '{8'h00, 8'h00, 8'ha4, 8'ha4, 8'h40, 8'h00};
    int bad_count = 0;
    int checks = 0;
    int ticks = 0;
    always #2 clock = ~clock;
    dta_adjust #(.CHANNELS(2)) dut (.clock(clock), .resetn(resetn),
        .monitor_tick(monitor_tick), .reg_address(reg_address),
        .reg_write(reg_write), .reg_write_data(reg_write_data),
        .reg_read(reg_read), .reg_read_data(reg_read_data),
        .reg_read_valid(reg_read_valid), .chan_in(chan_in),
        .threshold_load(threshold_load), .fan_on_threshold(fan_on_threshold));
    // ==========
    // Tasks
    task automatic step();
        @(posedge clock);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        step();
        reg_address = a;
        reg_write_data = d;
        reg_write = 1;
        step();
        reg_write = 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        step();
        reg_address = a;
        reg_read = 1;
        step();
        reg_read = 0;
        `CHK("read data", e, reg_read_data)
        `CHK("read valid", 1'b1, reg_read_valid)
    endtask
    // Ticks are two cycles apart so every update lands before the next.
    task automatic tick(input int n);
        repeat (n) begin
            step();
            monitor_tick = 1;
            step();
            monitor_tick = 0;
            ticks++;
        end
    endtask
    task automatic load(input logic [7:0] v);
        step();
        threshold_load[0] = '{1'b1, v};
        step();
        threshold_load[0].load = 0;
    endtask
    // A load value of ff means keep the running threshold.
    task automatic phase(input logic [9:0] t, input logic [7:0] lo, hi, ld,
        input int n, input logic [7:0] e);
        chan_in[0] = '{t, lo, hi};
        chan_in[1] = chan_in[0];
        if (ld != 8'hff) load(ld);
        while (ticks % 16 != 0) tick(1);
        tick(n);
        step();
        `CHK("threshold", e, fan_on_threshold[0])
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ==========
    // Tests
    initial begin
        #200000;
        bad_count++;
        end_of_test();
    end
    initial begin
        chan_in[0] = '{10'h130, 8'h40, 8'h60};
        chan_in[1] = chan_in[0];
        threshold_load[0] = '{1'b0, 8'h00};
        threshold_load[1] = '{1'b0, 8'h00};
        repeat (8) @(posedge clock);
        #1 resetn = 1;
        foreach (ra[i]) rd(ra[i], re[i]);
        wr(8'h0c, 8'h3f);
        rd(8'h0c, 8'h3f);
        wr(8'h0b, 8'hff);
        rd(8'h0b, 8'h03);
        wr(8'h5b, 8'h77);
        rd(8'h5b, 8'h77);
        wr(8'h33, 8'h55);
        rd(8'h33, 8'h00);
        wr(8'h0b, 8'h01);
        wr(8'h0c, 8'h00);
        wr(8'h5a, 8'h50);
        phase({8'h4c, 2'h0}, 8'h40, 8'h60, 8'h30, 16, 8'h30);
        phase({8'h4d, 2'h0}, 8'h40, 8'h60, 8'h40, 16, 8'h3e);
        phase({8'h51, 2'h0}, 8'h40, 8'h60, 8'hff, 16, 8'h35);
        phase({8'h51, 2'h1}, 8'h40, 8'h60, 8'hff, 16, 8'h34);
        phase({8'h51, 2'h3}, 8'h40, 8'h60, 8'hff, 16, 8'h32);
        phase({8'h48, 2'h0}, 8'h50, 8'h34, 8'hff, 48, 8'h34);
        phase({8'h58, 2'h0}, 8'h40, 8'h70, 8'h60, 16, 8'h60);
        wr(8'h0b, 8'h00);
        phase({8'h58, 2'h0}, 8'h40, 8'h70, 8'h50, 16, 8'h50);
        wr(8'h0b, 8'h01);
        phase({8'h70, 2'h0}, 8'h40, 8'h70, 8'h01, 16, 8'h00);
        wr(8'h5a, 8'h60);
        for (int c = 0; c < 8; c++) begin
            wr(8'h0c, 8'(c));
            while (ticks % (16 << c) != 0) tick(1);
            load(8'h50);
            tick(8 << c);
            `CHK("short only", 8'h50, fan_on_threshold[0])
            tick(8 << c);
            `CHK("long", 8'h4f, fan_on_threshold[0])
        end
        `CHK("second channel", 8'h00, fan_on_threshold[1])
        end_of_test();
    end
endmodule

bind dta_adjust dta_adjust_chk #(.CHANNELS(CHANNELS)) chk (.clock(clock),
    .resetn(resetn), .monitor_tick(monitor_tick), .reg_read(reg_read),
    .reg_read_valid(reg_read_valid), .chan_in(chan_in),
    .threshold_load(threshold_load), .fan_on_threshold(fan_on_threshold));
